/* File: work_bit_pkg.sv */
// Shared constants and carrier types for the work bit logic unit.
// Assumes a single clock domain; configuration arrives as static levels.
package work_bit_pkg;

  localparam int NUM_BITS = 8;
  localparam int NUM_INPUTS = 4;
  localparam int SRC_W = 6;
  localparam int NUM_SRC = 36;
  localparam int OP_W = 3;
  localparam int NUM_EVT = 4;

  // Operation types
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_SOP = 3'h1;
  localparam logic [2:0] OP_POS = 3'h2;
  localparam logic [2:0] OP_OR4 = 3'h3;
  localparam logic [2:0] OP_AND4 = 3'h4;

  // Source codes
  localparam logic [5:0] SRC_ZERO = 6'h00;
  localparam logic [5:0] SRC_ONE = 6'h01;
  localparam logic [5:0] SRC_POWER_UP = 6'h02;
  localparam logic [5:0] SRC_EVT_FIRST = 6'h03;
  localparam logic [5:0] SRC_ALARM1 = 6'h07;
  localparam logic [5:0] SRC_ALARM2 = 6'h08;
  localparam logic [5:0] SRC_ALARM3 = 6'h09;
  localparam logic [5:0] SRC_COUNT_ALARM = 6'h0A;
  localparam logic [5:0] SRC_CTRL_OUT1 = 6'h0B;
  localparam logic [5:0] SRC_CTRL_OUT2 = 6'h0C;
  localparam logic [5:0] SRC_INPUT_ERR = 6'h0D;
  localparam logic [5:0] SRC_RSVD14 = 6'h0E;
  localparam logic [5:0] SRC_BURNOUT = 6'h0F;
  localparam logic [5:0] SRC_SHORT = 6'h10;
  localparam logic [5:0] SRC_OVERCUR = 6'h11;
  localparam logic [5:0] SRC_AUTO_MAN = 6'h12;
  localparam logic [5:0] SRC_RUN_STOP = 6'h13;
  localparam logic [5:0] SRC_RSVD20 = 6'h14;
  localparam logic [5:0] SRC_PROG_START = 6'h15;
  localparam logic [5:0] SRC_TUNE = 6'h16;
  localparam logic [5:0] SRC_RAMP = 6'h17;
  localparam logic [5:0] SRC_MSP_B0 = 6'h18;
  localparam logic [5:0] SRC_MSP_B1 = 6'h19;
  localparam logic [5:0] SRC_RSVD26 = 6'h1A;
  localparam logic [5:0] SRC_PROG_END = 6'h1B;
  localparam logic [5:0] SRC_WORK_FIRST = 6'h1C;

  // Reset values
  localparam logic [7:0] WORK_RST = 8'h00;

  // Controller status inputs, same clock domain
  typedef struct packed {
    logic alarm1;
    logic alarm2;
    logic alarm3;
    logic count_alarm_out1;
    logic count_alarm_out2;
    logic ctrl_out1;
    logic ctrl_out1_is_current;
    logic ctrl_out2;
    logic ctrl_out2_present;
    logic input_err;
    logic heater_burnout_alarm;
    logic heater_short_alarm;
    logic heater_overcurrent_alarm;
    logic auto_manual;
    logic run_stop;
    logic prog_start;
    logic auto_tune;
    logic set_point_ramp;
    logic [1:0] multi_set_point;
    logic prog_end;
  } ctrl_status_t;

  // Per work bit configuration
  typedef struct packed {
    logic [OP_W-1:0] op;
    logic [NUM_INPUTS-1:0][SRC_W-1:0] src;
    logic [NUM_INPUTS-1:0] in_inv;
    logic out_inv;
  } work_cfg_t;

endpackage

/* File: work_bit_sync.sv */
// Two flip-flop synchroniser for a vector of asynchronous pins.
// Assumes inputs are slow levels; no glitch filtering.
`timescale 1ns/1ps
module work_bit_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  always_comb
  begin
    nxt_state.meta = async_i;
    nxt_state.sync = state_ff.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign sync_o = state_ff.sync;
endmodule

/* File: work_bit_eval.sv */
// Combinational evaluation of one work bit from its source vector.
// Assumes the source vector is already registered or synchronised.
`timescale 1ns/1ps
module work_bit_eval
  import work_bit_pkg::*;
(
  // Configuration
  input work_bit_pkg::work_cfg_t cfg_i,
  // Sources
  input wire logic [work_bit_pkg::NUM_SRC-1:0] src_vec_i,
  // Result
  output logic result_o
);
  logic [NUM_INPUTS-1:0] in_val;
  logic comb_res;

  for (genvar k = 0; k < NUM_INPUTS; k++)
  begin : g_in
    // Codes beyond the table read as zero
    assign in_val[k] = ((cfg_i.src[k] < SRC_W'(NUM_SRC)) ? src_vec_i[cfg_i.src[k]] : 1'b0)
                       ^ cfg_i.in_inv[k];
  end

  always_comb
  begin
    case (cfg_i.op)
      OP_SOP: comb_res = (in_val[0] & in_val[1]) | (in_val[2] & in_val[3]);
      OP_POS: comb_res = (in_val[0] | in_val[2]) & (in_val[1] | in_val[3]);
      OP_OR4: comb_res = |in_val;
      OP_AND4: comb_res = &in_val;
      default: comb_res = 1'b0;
    endcase
  end

  // No-operation stays 0 even with output inversion
  assign result_o = (cfg_i.op == OP_NONE) ? 1'b0 : (comb_res ^ cfg_i.out_inv);
endmodule

/* File: work_bit_logic_unit.sv */
// Summary of operation
// - Eight independent work bits, each with operation, four sources and inversions.
// - After reset all work bits read 0 until the first scan.
// - Indicator dot is lit while any work bit has an operation.
// - Operation 1: (A and B) or (C and D).
// - Operation 2: (A or C) and (B or D).
// - Operation 4: A and B and C and D.
// - Source 0 is 0, 1 is 1, 2 pulses one scan after power-up.
// - Sources 3 to 6 are event inputs 1 to 4, absent ones unavailable.
// - Sources 7 to 9 are alarms 1 to 3; 10 ORs count alarms.
// - Source 11 is control output 1, zero when it is a current output.
// - Source 12 is control output 2, zero when that output is absent.
// - Source 13 input error; 15 to 17 burnout, short, overcurrent alarms.
// - Sources 18,19,21,22,23: auto/manual, run/stop, program start, auto-tune, ramp.
// - Sources 24, 25 are multi set point bits; 27 is program end.
// - All inputs share one encoding; 28 to 35 feed back work bits 1 to 8.
// - Each input has its own inversion before combination.
// - Each work bit has an output inversion before storing.
// - Work bit values are outputs for routing and state switching.
//
// Top of the work bit logic unit: evaluates all work bits once per scan.
// Assumes scan_i is a one-cycle pulse from the controller sequencer and
// configuration and status inputs come from logic on clk_i.
`timescale 1ns/1ps
module work_bit_logic_unit
  import work_bit_pkg::*;
#(
  parameter int NUM_WORK = 8,
  parameter logic [3:0] EVT_PRESENT = 4'hF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Scan timing
  input wire logic scan_i,
  // Configuration
  input work_bit_pkg::work_cfg_t [7:0] cfg_i,
  // Controller status
  input work_bit_pkg::ctrl_status_t status_i,
  // External event pins
  input wire logic [3:0] event_pin_i,
  // Results
  output logic [7:0] work_bit_o,
  output logic logic_dot_o
);
  import work_bit_pkg::*;

  if (NUM_WORK != NUM_BITS)
  begin : g_bad_num
    $error("work_bit_logic_unit: NUM_WORK must be 8");
  end

  typedef struct packed {
    logic [NUM_BITS-1:0] work;
    logic first_done;
    logic power_pulse;
    logic dot;
  } unit_state_t;

  unit_state_t state_ff;
  unit_state_t nxt_state;
  logic [NUM_EVT-1:0] evt_sync;
  logic [NUM_SRC-1:0] src_vec;
  logic [NUM_BITS-1:0] result;
  logic any_op;

  work_bit_sync #(
    .WIDTH(NUM_EVT)
  ) u_evt_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(event_pin_i),
    .sync_o(evt_sync)
  );

  // One shared source vector serves every input of every work bit
  always_comb
  begin
    src_vec = '0;
    src_vec[SRC_ZERO] = 1'b0;
    src_vec[SRC_ONE] = 1'b1;
    src_vec[SRC_POWER_UP] = state_ff.power_pulse;
    for (int e = 0; e < NUM_EVT; e++)
    begin
      src_vec[SRC_EVT_FIRST + e] = evt_sync[e] & EVT_PRESENT[e];
    end
    src_vec[SRC_ALARM1] = status_i.alarm1;
    src_vec[SRC_ALARM2] = status_i.alarm2;
    src_vec[SRC_ALARM3] = status_i.alarm3;
    src_vec[SRC_COUNT_ALARM] = status_i.count_alarm_out1 | status_i.count_alarm_out2;
    src_vec[SRC_CTRL_OUT1] = status_i.ctrl_out1 & ~status_i.ctrl_out1_is_current;
    src_vec[SRC_CTRL_OUT2] = status_i.ctrl_out2 & status_i.ctrl_out2_present;
    src_vec[SRC_INPUT_ERR] = status_i.input_err;
    src_vec[SRC_RSVD14] = 1'b0;
    src_vec[SRC_BURNOUT] = status_i.heater_burnout_alarm;
    src_vec[SRC_SHORT] = status_i.heater_short_alarm;
    src_vec[SRC_OVERCUR] = status_i.heater_overcurrent_alarm;
    src_vec[SRC_AUTO_MAN] = status_i.auto_manual;
    src_vec[SRC_RUN_STOP] = status_i.run_stop;
    src_vec[SRC_RSVD20] = 1'b0;
    src_vec[SRC_PROG_START] = status_i.prog_start;
    src_vec[SRC_TUNE] = status_i.auto_tune;
    src_vec[SRC_RAMP] = status_i.set_point_ramp;
    src_vec[SRC_MSP_B0] = status_i.multi_set_point[0];
    src_vec[SRC_MSP_B1] = status_i.multi_set_point[1];
    src_vec[SRC_RSVD26] = 1'b0;
    src_vec[SRC_PROG_END] = status_i.prog_end;
    // Feedback uses last scan's values, so loops cannot oscillate within a scan
    for (int w = 0; w < NUM_BITS; w++)
    begin
      src_vec[SRC_WORK_FIRST + w] = state_ff.work[w];
    end
  end

  for (genvar w = 0; w < NUM_BITS; w++)
  begin : g_work
    work_bit_eval u_eval (
      .cfg_i(cfg_i[w]),
      .src_vec_i(src_vec),
      .result_o(result[w])
    );
  end

  always_comb
  begin
    any_op = 1'b0;
    for (int w = 0; w < NUM_BITS; w++)
    begin
      any_op = any_op | (cfg_i[w].op != OP_NONE);
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.dot = any_op;
    if (scan_i)
    begin
      nxt_state.work = result;
      // Power-up source is set by the first scan and is high during the second scan only
      nxt_state.power_pulse = ~state_ff.first_done;
      nxt_state.first_done = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff.work <= WORK_RST;
      state_ff.first_done <= 1'b0;
      state_ff.power_pulse <= 1'b0;
      state_ff.dot <= 1'b0;
    end
    else
      state_ff <= nxt_state;
  end

  assign work_bit_o = state_ff.work;
  assign logic_dot_o = state_ff.dot;

  // Reference view of work bit 1 inputs, read by the checks only
  logic [NUM_INPUTS-1:0] chk_sel;
  logic [NUM_INPUTS-1:0] chk_in;
  logic [NUM_BITS-1:0] noop_mask;

  always_comb
  begin
    chk_sel = '0;
    chk_in = '0;
    noop_mask = '0;
    for (int k = 0; k < NUM_INPUTS; k++)
    begin
      if (cfg_i[0].src[k] < SRC_W'(NUM_SRC))
      begin
        chk_sel[k] = src_vec[cfg_i[0].src[k]];
      end
      chk_in[k] = chk_sel[k] ^ cfg_i[0].in_inv[k];
    end
    for (int w = 0; w < NUM_BITS; w++)
    begin
      noop_mask[w] = (cfg_i[w].op == OP_NONE);
    end
  end

  // Assertions

  // Storage and no-operation
  AST_WORK_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !$past(scan_i) |-> $stable(work_bit_o))
    else $error("work bits changed without a scan");

  AST_NOOP_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (scan_i && cfg_i[0].op == OP_NONE) |=> !work_bit_o[0])
    else $error("no-operation work bit not zero");

  AST_NOOP_ALL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    scan_i |=> ((work_bit_o & $past(noop_mask)) == '0))
    else $error("a no-operation work bit is set");

  // Indicator dot
  AST_DOT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    any_op |=> logic_dot_o)
    else $error("indicator dot missing");

  AST_DOT_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !any_op |=> !logic_dot_o)
    else $error("indicator dot lit without operation");

  // Operation types, checked on work bit 1
  AST_SOP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (scan_i && cfg_i[0].op == OP_SOP && !cfg_i[0].out_inv)
    |=> work_bit_o[0] == $past((chk_in[0] & chk_in[1]) | (chk_in[2] & chk_in[3])))
    else $error("sum of products wrong");

  AST_POS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (scan_i && cfg_i[0].op == OP_POS && !cfg_i[0].out_inv)
    |=> work_bit_o[0] == $past((chk_in[0] | chk_in[2]) & (chk_in[1] | chk_in[3])))
    else $error("product of sums wrong");

  AST_OR4: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (scan_i && cfg_i[0].op == OP_OR4 && !cfg_i[0].out_inv)
    |=> work_bit_o[0] == $past(|chk_in))
    else $error("four-way OR wrong");

  AST_AND4: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (scan_i && cfg_i[0].op == OP_AND4 && !cfg_i[0].out_inv && cfg_i[0].src == '0
     && cfg_i[0].in_inv == 4'hF) |=> work_bit_o[0])
    else $error("four-way AND wrong");

  AST_AND4_REF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (scan_i && cfg_i[0].op == OP_AND4 && !cfg_i[0].out_inv)
    |=> work_bit_o[0] == $past(&chk_in))
    else $error("four-way AND against inputs wrong");

  // Constant and power-up sources
  AST_CONSTS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !src_vec[SRC_ZERO] && src_vec[SRC_ONE])
    else $error("constant sources wrong");

  AST_PULSE_FIRST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (scan_i && !state_ff.first_done) |=> state_ff.power_pulse)
    else $error("power-up pulse missing");

  AST_PULSE_ONCE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (scan_i && state_ff.first_done) |=> !state_ff.power_pulse)
    else $error("power-up pulse repeated");

  AST_PULSE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !scan_i |=> $stable(state_ff.power_pulse))
    else $error("power-up pulse moved between scans");

  // Event inputs
  AST_EVT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    src_vec[SRC_EVT_FIRST +: NUM_EVT] == (evt_sync & EVT_PRESENT))
    else $error("event source wrong");

  AST_EVT_ABSENT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (src_vec[SRC_EVT_FIRST +: NUM_EVT] & ~EVT_PRESENT) == '0)
    else $error("absent event input not zero");

  // Alarms and control outputs
  AST_ALARMS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    src_vec[SRC_ALARM1 +: 3] == {status_i.alarm3, status_i.alarm2, status_i.alarm1})
    else $error("alarm source wrong");

  AST_COUNT_ALARM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    src_vec[SRC_COUNT_ALARM] == (status_i.count_alarm_out1 | status_i.count_alarm_out2))
    else $error("count alarm source wrong");

  AST_CUR_OUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    status_i.ctrl_out1_is_current |-> !src_vec[SRC_CTRL_OUT1])
    else $error("current output leaked");

  AST_OUT1_PASS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !status_i.ctrl_out1_is_current |-> src_vec[SRC_CTRL_OUT1] == status_i.ctrl_out1)
    else $error("control output 1 source wrong");

  AST_NO_OUT2: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !status_i.ctrl_out2_present |-> !src_vec[SRC_CTRL_OUT2])
    else $error("missing output 2 leaked");

  AST_OUT2_PASS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    status_i.ctrl_out2_present |-> src_vec[SRC_CTRL_OUT2] == status_i.ctrl_out2)
    else $error("control output 2 source wrong");

  AST_HEATER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    src_vec[SRC_INPUT_ERR] == status_i.input_err && src_vec[SRC_BURNOUT +: 3] ==
    {status_i.heater_overcurrent_alarm, status_i.heater_short_alarm, status_i.heater_burnout_alarm})
    else $error("error or heater source wrong");

  // Reserved codes
  AST_RSVD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(src_vec[SRC_RSVD14] | src_vec[SRC_RSVD20] | src_vec[SRC_RSVD26]))
    else $error("reserved source not zero");

  AST_RSVD_USE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (scan_i && cfg_i[0].op == OP_OR4 && !cfg_i[0].out_inv && cfg_i[0].in_inv == 4'h0
     && cfg_i[0].src == {4{SRC_RSVD14}}) |=> !work_bit_o[0])
    else $error("reserved code gave a one");

  // Operating states
  AST_STATES: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    src_vec[SRC_AUTO_MAN] == status_i.auto_manual && src_vec[SRC_RUN_STOP] == status_i.run_stop
    && src_vec[SRC_PROG_START +: 3] == {status_i.set_point_ramp, status_i.auto_tune, status_i.prog_start})
    else $error("state source wrong");

  AST_MSP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    src_vec[SRC_MSP_B0 +: 2] == status_i.multi_set_point && src_vec[SRC_PROG_END] == status_i.prog_end)
    else $error("set point or program end source wrong");

  // Feedback
  AST_FEEDBACK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    src_vec[SRC_WORK_FIRST +: NUM_BITS] == work_bit_o)
    else $error("feedback mismatch");

  AST_FEEDBACK_SCAN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (scan_i && cfg_i[1].op == OP_OR4 && !cfg_i[1].out_inv && cfg_i[1].in_inv == 4'h0
     && cfg_i[1].src == {4{SRC_WORK_FIRST}}) |=> work_bit_o[1] == $past(work_bit_o[0]))
    else $error("feedback did not use the previous scan");

  // Inversions
  AST_IN_INV: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (scan_i && cfg_i[0].op == OP_OR4 && !cfg_i[0].out_inv && cfg_i[0].in_inv == 4'hF
     && cfg_i[0].src == '0) |=> work_bit_o[0])
    else $error("input inversion missing");

  AST_OUT_INV: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (scan_i && cfg_i[0].op == OP_OR4 && cfg_i[0].out_inv)
    |=> work_bit_o[0] == !$past(|chk_in))
    else $error("output inversion missing");

  // Routing
  AST_SCAN_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    scan_i |=> work_bit_o == $past(result))
    else $error("scan result not presented");

  COV_FIRST_SCAN: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    scan_i && !state_ff.first_done);

  COV_WORK_SET: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(work_bit_o[0]));

  COV_DOT_ON: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(logic_dot_o));

  COV_FEEDBACK_SET: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    scan_i && cfg_i[1].src[0] == SRC_WORK_FIRST && work_bit_o[0]);

  COV_INVERTED: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    scan_i && cfg_i[0].out_inv && cfg_i[0].op != OP_NONE);
endmodule

/* File: status_model.sv */
// Behavioural far side: controller status flags and external event pins.
// Assumes the bench hands it one flat stimulus word, status in the upper bits.
`timescale 1ns/1ps
module status_model
  import work_bit_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Stimulus
  input wire logic [24:0] stim_i,
  // Far side levels
  output work_bit_pkg::ctrl_status_t status_o,
  output logic [3:0] event_pin_o
);
  import work_bit_pkg::*;

  ctrl_status_t status_ff = '0;

  // Status comes from controller logic on clk_i
  always @(posedge clk_i)
  begin
    status_ff <= stim_i[24:4];
  end
  assign status_o = status_ff;
  // Pins move off the clock grid to exercise the synchroniser
  assign #7 event_pin_o = stim_i[3:0];
endmodule

/* File: tb.sv */
// Self-checking bench for the work bit logic unit.
// Assumes scan latency of one cycle and two-cycle event synchronisation.
`timescale 1ns/1ps
module tb;
  import work_bit_pkg::*;

  // Event input 4 absent, to see it read as 0
  localparam logic [3:0] EVT_EN = 4'h7;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic scan_i = 1'b0;
  work_cfg_t [7:0] cfg = '0;
  logic [24:0] stim = '0;
  ctrl_status_t status;
  logic [3:0] event_pin;
  logic [7:0] work_bit;
  logic dot;
  logic [7:0] exp_w;
  logic [5:0] code;
  int fails = 0;
  int samples_checked = 0;

  always #12.5 clk_i = ~clk_i;

  status_model i_model (.clk_i(clk_i), .stim_i(stim), .status_o(status), .event_pin_o(event_pin));

  work_bit_logic_unit #(.NUM_WORK(8), .EVT_PRESENT(EVT_EN)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scan_i(scan_i), .cfg_i(cfg), .status_i(status),
    .event_pin_i(event_pin), .work_bit_o(work_bit), .logic_dot_o(dot));

  task automatic check_bits(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic check_dot(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Bench inputs move 2 ns after the rising edge; the model moves event pins 7 ns after that
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic scan_once();
    scan_i = 1'b1;
    step(1);
    scan_i = 1'b0;
  endtask

  function automatic logic exp_op(input logic [2:0] op, input logic [3:0] x, input logic inv);
    case (op)
      3'h1: exp_op = ((x[0] & x[1]) | (x[2] & x[3])) ^ inv;
      3'h2: exp_op = ((x[0] | x[2]) & (x[1] | x[3])) ^ inv;
      3'h3: exp_op = (|x) ^ inv;
      3'h4: exp_op = (&x) ^ inv;
      3'h0: exp_op = 1'b0;
      // Undefined codes evaluate to 0, so only the output inversion shows
      default: exp_op = inv;
    endcase
  endfunction

  function automatic logic exp_src(input logic [5:0] c, input logic [24:0] s);
    ctrl_status_t st;
    st = s[24:4];
    case (c)
      6'h01: exp_src = 1'b1;
      6'h03, 6'h04, 6'h05, 6'h06: exp_src = s[2'(c - 6'h03)] & EVT_EN[2'(c - 6'h03)];
      6'h07: exp_src = st.alarm1;
      6'h08: exp_src = st.alarm2;
      6'h09: exp_src = st.alarm3;
      6'h0A: exp_src = st.count_alarm_out1 | st.count_alarm_out2;
      6'h0B: exp_src = st.ctrl_out1 & ~st.ctrl_out1_is_current;
      6'h0C: exp_src = st.ctrl_out2 & st.ctrl_out2_present;
      6'h0D: exp_src = st.input_err;
      6'h0F: exp_src = st.heater_burnout_alarm;
      6'h10: exp_src = st.heater_short_alarm;
      6'h11: exp_src = st.heater_overcurrent_alarm;
      6'h12: exp_src = st.auto_manual;
      6'h13: exp_src = st.run_stop;
      6'h15: exp_src = st.prog_start;
      6'h16: exp_src = st.auto_tune;
      6'h17: exp_src = st.set_point_ramp;
      6'h18: exp_src = st.multi_set_point[0];
      6'h19: exp_src = st.multi_set_point[1];
      6'h1B: exp_src = st.prog_end;
      default: exp_src = 1'b0;
    endcase
  endfunction

  initial
  begin
    #100000;
    fails++;
    tally_and_finish();
  end

  initial
  begin
    step(3);
    check_bits(work_bit, 8'h00, "reset bits");
    check_dot(dot, 1'b0, "reset dot");
    rst_n_i = 1'b1;
    cfg[0].op = OP_OR4;
    cfg[0].src[0] = SRC_POWER_UP;
    cfg[1].op = OP_OR4;
    cfg[1].src[0] = SRC_ONE;
    scan_once();
    check_bits(work_bit, 8'h02, "first scan");
    scan_once();
    check_bits(work_bit, 8'h03, "power-up pulse");
    scan_once();
    check_bits(work_bit, 8'h02, "pulse gone");
    check_dot(dot, 1'b1, "dot lit");
    cfg = '0;
    scan_once();
    check_bits(work_bit, 8'h00, "no operation");
    check_dot(dot, 1'b0, "dot dark");
    // Chain through feedback codes with back-to-back scans
    cfg[0].op = OP_OR4;
    cfg[0].src[0] = SRC_ONE;
    for (int j = 1; j < 8; j++)
    begin
      cfg[j].op = OP_OR4;
      cfg[j].src[0] = SRC_WORK_FIRST + 6'(j - 1);
    end
    exp_w = 8'h00;
    scan_i = 1'b1;
    for (int n = 0; n < 8; n++)
    begin
      step(1);
      exp_w = {exp_w[6:0], 1'b1};
      check_bits(work_bit, exp_w, "feedback");
    end
    scan_i = 1'b0;
    for (int op = 0; op < 8; op++)
      for (int p = 0; p < 16; p++)
      begin
        for (int j = 0; j < 8; j++)
        begin
          cfg[j].op = 3'(op);
          cfg[j].in_inv = 4'(j * 3);
          cfg[j].out_inv = j[0];
          for (int i = 0; i < 4; i++)
            cfg[j].src[i] = p[i] ? SRC_ONE : SRC_ZERO;
          exp_w[j] = exp_op(3'(op), 4'(p) ^ 4'(j * 3), j[0]);
        end
        scan_once();
        check_bits(work_bit, exp_w, "operation");
        check_dot(dot, op != 0, "dot per op");
      end
    // Walk one hot status or pin, with and without the output qualifiers
    for (int b = 0; b < 2; b++)
      for (int k = 0; k < 26; k++)
      begin
        stim = (25'h1 << k) | (b != 0 ? 25'h0050000 : 25'h0);
        step(4);
        for (int c = 0; c < 32; c += 8)
        begin
          for (int j = 0; j < 8; j++)
          begin
            code = 6'(c + j > 27 ? c + j + 9 : c + j);
            cfg[j] = '0;
            cfg[j].op = OP_OR4;
            cfg[j].src[0] = code;
            exp_w[j] = exp_src(code, stim);
          end
          scan_once();
          check_bits(work_bit, exp_w, "source");
        end
      end
    tally_and_finish();
  end
endmodule
